// File: design/ipr_pkg.sv
// Constants, register map and source table of the interrupt priority resolver.
// Assumes a 16-bit register port and 12-bit event codes toward the CPU core.
package ipr_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int LVL_W  = 5;
    localparam int CODE_W = 12;
    localparam int IDX_W  = 5;
    localparam int SRC_N  = 31;
    localparam int PRIO_N = 5;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFS_PRIO_A      = 4'h0;
    localparam logic [3:0] OFS_PRIO_E      = 4'h4;
    localparam logic [3:0] OFS_NMI_CTRL    = 4'h5;
    localparam logic [3:0] OFS_EXT_CTRL    = 4'h6;
    localparam logic [3:0] OFS_LEVEL_CODE  = 4'h7;
    localparam logic [3:0] OFS_SOURCE_CODE = 4'h8;

    // Priority register indices and writable-bit masks.
    localparam int PRIO_A = 0;
    localparam int PRIO_B = 1;
    localparam int PRIO_C = 2;
    localparam int PRIO_D = 3;
    localparam int PRIO_E = 4;
    localparam logic [15:0] PRIO_MASK [PRIO_N] =
        '{16'hFFFF, 16'hFFF0, 16'hFFFF, 16'h00FF, 16'hF0FF};
    localparam logic [15:0] PRIO_RESET     = 16'h0000;
    localparam logic        NMI_EDGE_RESET = 1'b0;
    localparam logic        ENC_SEL_RESET  = 1'b1;

    // Bit positions in the control registers.
    localparam int NMI_LEVEL_BIT = 15;
    localparam int NMI_EDGE_BIT  = 8;
    localparam int ENC_SEL_BIT   = 14;

    // Fixed levels and event codes.
    localparam logic [4:0]  LVL_NMI         = 5'h10;
    localparam logic [4:0]  LVL_DEBUG       = 5'h0F;
    localparam logic [4:0]  LVL_TOP         = 5'h0F;
    localparam logic [3:0]  ENC_NONE        = 4'hF;
    localparam logic [11:0] NMI_CODE        = 12'h1C0;
    localparam logic [11:0] DEBUG_CODE      = 12'h5E0;
    localparam logic [11:0] LEVEL_CODE_TOP  = 12'h200;
    localparam logic [11:0] IRQ_BASE        = 12'h600;
    localparam logic [11:0] DMA_BASE        = 12'h800;
    localparam logic [11:0] FSER_BASE       = 12'h900;
    localparam logic [11:0] ADC_CODE        = 12'h980;
    localparam logic [11:0] FIXED_BASE      = 12'h400;

    // Source indices in default order, index 0 first.
    localparam logic [4:0] IDX_NMI   = 5'h00;
    localparam logic [4:0] IDX_DEBUG = 5'h01;
    localparam logic [4:0] IDX_IRQ   = 5'h02;
    localparam logic [4:0] IDX_DMA   = 5'h08;
    localparam logic [4:0] IDX_FSER  = 5'h0C;
    localparam logic [4:0] IDX_ADC   = 5'h10;
    localparam logic [4:0] IDX_FIXED = 5'h11;

    // Edge detection is blind this many cycles after an edge-select change.
    localparam logic [4:0] NMI_BLANK_CYCLES = 5'h14;

endpackage

// File: design/ipr_select.sv
// Picks the highest level among pending sources; lower index wins ties.
// Assumes levels are packed LVL_W bits per source, source 0 lowest.
`timescale 1ns/1ps

module ipr_select
    import ipr_pkg::*;
(
    input  wire logic [ipr_pkg::SRC_N-1:0]       pend,
    input  wire logic [ipr_pkg::SRC_N*ipr_pkg::LVL_W-1:0] lvl_flat,
    output logic                                 found,
    output logic [ipr_pkg::IDX_W-1:0]            win_idx,
    output logic [ipr_pkg::LVL_W-1:0]            win_lvl
);

    // ------------------------------------------------------------
    // Linear scan
    // ------------------------------------------------------------
    // Strict comparison keeps the earlier source on a tie, so the
    // scan order is the default order.
    always_comb begin
        found   = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        for (int i = 0; i < SRC_N; i++) begin
            if (pend[i] && (lvl_flat[i*LVL_W +: LVL_W] > win_lvl)) begin
                found   = 1'b1;
                win_idx = IDX_W'(i);
                win_lvl = lvl_flat[i*LVL_W +: LVL_W];
            end
        end
    end

endmodule

// File: design/ipr_resolver.sv
// Interrupt priority resolver: priority registers, source table, event codes.
// Assumes request inputs are already detected levels, synchronous to ref_clk.
//
// Contract
// - Every source gets a distinct event code; one shared routine address.
// - Software sets each grouped source priority 0..15 via five registers.
// - Reset sets all programmable priorities to zero, masking those sources.
// - Equal-level simultaneous requests are served in fixed default order.
// - Nonmaskable source has fixed level 16 and code 0x1C0 in both.
// - Debug source has fixed level 15 and code 0x5E0 in both.
// - Pin, DMA, FIFO serial, ADC: level code first, per-source code second.
// - Level code is 0x200 at level 15, plus 0x20 per lower level.
// - Timer to refresh sources give fixed codes 0x400..0x5A0 in both.
// - Encoded input 0000 is level 15, each step lower; pins 4,5 stay.
// - Sources sharing one priority field keep a fixed order inside it.
// - Register A holds timers and clock; B holds watchdog, refresh, serial.
// - C holds pins 3..0, D pins 5,4, E DMA, FIFO serial, ADC.
// - A 4-bit field is the level itself; zero masks, 0xF is 15.
// - Priority registers clear on reset and hardware standby only.
// - Reserved priority fields read zero; software writes zero there.
// - Nonmaskable control register clears on reset, holds through standby.
// - Control bit 14 picks separate pins or encoded bus; resets to one.
// - Edge select bit 8: zero falling, one rising nonmaskable edge.
// - Read-only bit 15 shows the present nonmaskable pin level.
// - Level zero masks a source; encoded 1111 is no request.
`timescale 1ns/1ps

module ipr_resolver
    import ipr_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic                        hw_standby,
    input  wire logic [ipr_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [ipr_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [ipr_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        nmi_pin,
    input  wire logic                        debug_interface_req,
    input  wire logic [5:0]                  irq_req,
    input  wire logic [3:0]                  encoded_level_bus,
    input  wire logic [3:0]                  dma_end,
    input  wire logic [3:0]                  fifo_serial_req,
    input  wire logic                        adc_done,
    input  wire logic                        timer0_underflow,
    input  wire logic                        timer1_underflow,
    input  wire logic [1:0]                  timer2_req,
    input  wire logic [2:0]                  clock_req,
    input  wire logic [3:0]                  serial0_req,
    input  wire logic                        watchdog_interval,
    input  wire logic [1:0]                  refresh_req,
    input  wire logic [3:0]                  cpu_mask_level,
    input  wire logic                        int_accept,
    output logic                             int_request,
    output logic      [ipr_pkg::LVL_W-1:0]   int_level,
    output logic      [ipr_pkg::CODE_W-1:0]  level_event_code_reg,
    output logic      [ipr_pkg::CODE_W-1:0]  source_event_code_reg
);

    import ipr_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0]                 prio [PRIO_N];
    logic                        nmi_edge_select;
    logic                        encoded_level_select;
    logic                        nmi_prev;
    logic                        nmi_pend;
    logic [4:0]                  nmi_blank;
    logic                        nmi_edge;
    logic                        irl_req;
    logic [5:0]                  irq_eff;
    logic [SRC_N-1:0]            raw_req;
    logic [SRC_N-1:0]            pend;
    logic [LVL_W-1:0]            src_lvl [SRC_N];
    logic [SRC_N*LVL_W-1:0]      lvl_flat;
    logic                        found;
    logic [IDX_W-1:0]            sel_idx;
    logic [LVL_W-1:0]            sel_lvl;
    logic                        win_valid;
    logic [IDX_W-1:0]            win_idx;
    logic [23:0]                 win_codes;
    logic                        taken;
    logic [DATA_W-1:0]           next_rdata;

    // ------------------------------------------------------------
    // Code helpers
    // ------------------------------------------------------------
    // One code step is 0x20, so a count shifts left by five.
    function automatic logic [11:0] step(input logic [4:0] n);
        return {2'b00, n, 5'h00};
    endfunction

    // Returns {level-dependent code, per-source code} for pin, DMA, FIFO serial, ADC; else {fixed, fixed}.
    function automatic logic [23:0] event_codes(input logic [4:0] idx,
                                                input logic [4:0] lvl,
                                                input logic       enc);
        logic [11:0] by_level;
        logic [11:0] fixed;
        by_level = LEVEL_CODE_TOP + step(LVL_TOP - lvl);
        if (idx == IDX_NMI) begin
            fixed = NMI_CODE;
        end else if (idx == IDX_DEBUG) begin
            fixed = DEBUG_CODE;
        end else if (idx == IDX_IRQ && enc) begin
            fixed = by_level;
        end else if (idx < IDX_DMA) begin
            fixed = IRQ_BASE + step(idx - IDX_IRQ);
        end else if (idx < IDX_FSER) begin
            fixed = DMA_BASE + step(idx - IDX_DMA);
        end else if (idx < IDX_ADC) begin
            fixed = FSER_BASE + step(idx - IDX_FSER);
        end else if (idx == IDX_ADC) begin
            fixed = ADC_CODE;
        end else begin
            fixed = FIXED_BASE + step(idx - IDX_FIXED);
        end
        // Pin, DMA, FIFO serial and ADC sources report the level code first.
        if (idx >= IDX_IRQ && idx <= IDX_ADC) begin
            return {by_level, fixed};
        end
        return {fixed, fixed};
    endfunction

    // ------------------------------------------------------------
    // Priority registers
    // ------------------------------------------------------------
    // Reserved bits are never stored, so they always read zero.
    // Ordinary standby has no input here: contents simply hold.
    for (genvar r = 0; r < PRIO_N; r++) begin : g_prio
        always_ff @(posedge ref_clk) begin
            if (!resetn || hw_standby) begin
                prio[r] <= PRIO_RESET;
            end else if (reg_wr && reg_addr == OFS_PRIO_A + 4'(r)) begin
                prio[r] <= reg_wdata & PRIO_MASK[r];
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // The edge select survives hardware standby; only reset clears it.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nmi_edge_select <= NMI_EDGE_RESET;
        end else if (reg_wr && reg_addr == OFS_NMI_CTRL) begin
            nmi_edge_select <= reg_wdata[NMI_EDGE_BIT];
        end
    end

    // Encoded mode is the reset default of the pin group.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            encoded_level_select <= ENC_SEL_RESET;
        end else if (reg_wr && reg_addr == OFS_EXT_CTRL) begin
            encoded_level_select <= reg_wdata[ENC_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Nonmaskable edge detection
    // ------------------------------------------------------------
    // Changing the edge select can look like an edge, so detection is
    // blind for a while after each write that changes it and after reset.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nmi_blank <= NMI_BLANK_CYCLES;
        end else if (reg_wr && reg_addr == OFS_NMI_CTRL &&
                     reg_wdata[NMI_EDGE_BIT] != nmi_edge_select) begin
            nmi_blank <= NMI_BLANK_CYCLES;
        end else if (nmi_blank != 5'h00) begin
            nmi_blank <= nmi_blank - 5'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nmi_prev <= 1'b0;
        end else begin
            nmi_prev <= nmi_pin;
        end
    end

    assign nmi_edge = (nmi_blank == 5'h00) &&
                      (nmi_edge_select ? (nmi_pin && !nmi_prev)
                                       : (!nmi_pin && nmi_prev));

    // A new edge in the accept cycle keeps the request pending.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nmi_pend <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pend <= 1'b1;
        end else if (taken && win_idx == IDX_NMI) begin
            nmi_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Source table in default order
    // ------------------------------------------------------------
    assign irl_req = encoded_level_select &&
                     (encoded_level_bus != ENC_NONE);
    // In encoded mode pins 3..0 vanish and slot 2 carries the bus.
    assign irq_eff = encoded_level_select ?
                     {irq_req[5:4], 3'b000, irl_req} : irq_req;

    assign raw_req = {refresh_req, watchdog_interval, serial0_req,
                      clock_req, timer2_req, timer1_underflow,
                      timer0_underflow, adc_done, fifo_serial_req,
                      dma_end, irq_eff, debug_interface_req,
                      nmi_pend};

    // Field per source; a field value is the level itself.
    always_comb begin
        src_lvl[IDX_NMI]   = LVL_NMI;
        src_lvl[IDX_DEBUG] = LVL_DEBUG;
        for (int k = 0; k < 4; k++) begin
            src_lvl[2 + k]  = {1'b0, prio[PRIO_C][4*k +: 4]};
            src_lvl[8 + k]  = {1'b0, prio[PRIO_E][15:12]};
            src_lvl[12 + k] = {1'b0, prio[PRIO_E][7:4]};
            src_lvl[24 + k] = {1'b0, prio[PRIO_B][7:4]};
        end
        if (encoded_level_select) begin
            src_lvl[IDX_IRQ] = LVL_TOP - {1'b0, encoded_level_bus};
        end
        src_lvl[6]  = {1'b0, prio[PRIO_D][3:0]};
        src_lvl[7]  = {1'b0, prio[PRIO_D][7:4]};
        src_lvl[16] = {1'b0, prio[PRIO_E][3:0]};
        src_lvl[17] = {1'b0, prio[PRIO_A][15:12]};
        src_lvl[18] = {1'b0, prio[PRIO_A][11:8]};
        src_lvl[19] = {1'b0, prio[PRIO_A][7:4]};
        src_lvl[20] = {1'b0, prio[PRIO_A][7:4]};
        src_lvl[21] = {1'b0, prio[PRIO_A][3:0]};
        src_lvl[22] = {1'b0, prio[PRIO_A][3:0]};
        src_lvl[23] = {1'b0, prio[PRIO_A][3:0]};
        src_lvl[28] = {1'b0, prio[PRIO_B][15:12]};
        src_lvl[29] = {1'b0, prio[PRIO_B][11:8]};
        src_lvl[30] = {1'b0, prio[PRIO_B][11:8]};
    end

    // A source at level zero is masked and never competes.
    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        assign pend[i] = raw_req[i] && (src_lvl[i] != 5'h00);
        assign lvl_flat[i*LVL_W +: LVL_W] = src_lvl[i];
    end

    ipr_select u_select (
        .pend     (pend),
        .lvl_flat (lvl_flat),
        .found    (found),
        .win_idx  (sel_idx),
        .win_lvl  (sel_lvl)
    );

    // ------------------------------------------------------------
    // Presentation to the CPU
    // ------------------------------------------------------------
    // The winner is registered; a source that drops in that cycle can
    // still be accepted once, which the core must tolerate.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            win_valid <= 1'b0;
            win_idx   <= '0;
            int_level <= '0;
        end else begin
            win_valid <= found;
            win_idx   <= sel_idx;
            int_level <= sel_lvl;
        end
    end

    assign int_request = win_valid &&
                         (int_level > {1'b0, cpu_mask_level});
    assign taken       = int_request && int_accept;
    assign win_codes   = event_codes(win_idx, int_level, encoded_level_select);

    // Both event code registers load together on acceptance.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            level_event_code_reg  <= '0;
            source_event_code_reg <= '0;
        end else if (taken) begin
            level_event_code_reg  <= win_codes[23:12];
            source_event_code_reg <= win_codes[11:0];
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            4'h0, 4'h1, 4'h2, 4'h3, OFS_PRIO_E: begin
                next_rdata = prio[3'(reg_addr)];
            end
            OFS_NMI_CTRL: begin
                next_rdata[NMI_LEVEL_BIT] = nmi_pin;
                next_rdata[NMI_EDGE_BIT]  = nmi_edge_select;
            end
            OFS_EXT_CTRL: begin
                next_rdata[ENC_SEL_BIT] = encoded_level_select;
            end
            OFS_LEVEL_CODE: begin
                next_rdata = {4'h0, level_event_code_reg};
            end
            OFS_SOURCE_CODE: begin
                next_rdata = {4'h0, source_event_code_reg};
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_nmi_code_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        taken && win_idx == IDX_NMI |=> level_event_code_reg == 12'h1C0
            && source_event_code_reg == 12'h1C0)
        else $error("nonmaskable codes not loaded");

    a_debug_code_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        taken && win_idx == IDX_DEBUG |=> level_event_code_reg == 12'h5E0
            && source_event_code_reg == 12'h5E0)
        else $error("debug codes not loaded");

    a_level_code_map: assert property (@(posedge ref_clk) disable iff (!resetn)
        taken && win_idx >= IDX_IRQ && win_idx <= IDX_ADC |=>
            level_event_code_reg ==
            12'h200 + {2'b00, 5'h0F - $past(int_level), 5'h00})
        else $error("level event code wrong");

    a_fixed_code_map: assert property (@(posedge ref_clk) disable iff (!resetn)
        taken && win_idx >= IDX_FIXED |=>
            source_event_code_reg == level_event_code_reg &&
            source_event_code_reg == 12'h400 + {2'b00, $past(win_idx) - 5'h11, 5'h00})
        else $error("fixed event code wrong");

    a_request_above_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
        int_request |-> int_level != 5'h00 && int_level > {1'b0, cpu_mask_level})
        else $error("request at or below mask");

    a_reset_clears_prio: assert property (@(posedge ref_clk)
        !resetn |=> prio[PRIO_A] == 16'h0000 && prio[PRIO_E] == 16'h0000
            && encoded_level_select == 1'b1)
        else $error("reset state wrong");

    a_reserved_read_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == 4'h3 |=> reg_rdata[15:8] == 8'h00)
        else $error("reserved field reads nonzero");

    a_pin_level_read: assert property (@(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr == OFS_NMI_CTRL |=> reg_rdata[15] == $past(nmi_pin))
        else $error("pin level bit wrong");

    a_encoded_none: assert property (@(posedge ref_clk) disable iff (!resetn)
        encoded_level_select && encoded_level_bus == 4'hF |-> !pend[IDX_IRQ])
        else $error("encoded 1111 requested");

    a_standby_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
        hw_standby |=> prio[PRIO_C] == 16'h0000 && prio[PRIO_B] == 16'h0000)
        else $error("standby did not clear");

endmodule

// File: dv/ipr_cpu_model.sv
// Behavioural CPU core that takes each interrupt the resolver presents.
// Assumes int_request settles just after each rising edge of ref_clk.
`timescale 1ns/1ps

module ipr_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       int_request,
    input  wire logic [3:0] gap,
    output logic            int_accept
);
    // ---------------------------------------------------------------
    // Acceptance
    // ---------------------------------------------------------------
    logic [3:0] wait_cnt;

    // A slow core is legal, so acceptance waits gap cycles of a standing request.
    always_ff @(posedge ref_clk) begin
        if (!resetn || !int_request || int_accept) begin
            int_accept <= 1'b0;
            wait_cnt   <= 4'h0;
        end else if (wait_cnt == gap) begin
            int_accept <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// File: dv/tb.sv
// Self-checking bench of the interrupt priority resolver.
// Assumes the CPU core model in ipr_cpu_model and the package constants.
`timescale 1ns/1ps

module tb;
    import ipr_pkg::*;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    logic        ref_clk, resetn, reg_wr, reg_rd, nmi_pin, dbg, int_accept, int_request;
    logic        hw_stby;
    logic [3:0]  reg_addr, bus, dma, mask;
    logic [15:0] reg_wdata, reg_rdata;
    logic [24:0] rest;
    logic [4:0]  int_level;
    logic [11:0] lc, sc;
    int          mismatches, comparisons;

    ipr_resolver DUT (.ref_clk, .resetn, .hw_standby(hw_stby), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .nmi_pin, .debug_interface_req(dbg),
        .irq_req(rest[5:0]), .encoded_level_bus(bus), .dma_end(dma),
        .fifo_serial_req(rest[9:6]), .adc_done(rest[10]), .timer0_underflow(rest[11]),
        .timer1_underflow(rest[12]), .timer2_req(rest[14:13]), .clock_req(rest[17:15]),
        .serial0_req(rest[21:18]), .watchdog_interval(rest[22]), .refresh_req(rest[24:23]),
        .cpu_mask_level(mask), .int_accept, .int_request, .int_level,
        .level_event_code_reg(lc), .source_event_code_reg(sc));
    ipr_cpu_model cpu (.ref_clk, .resetn, .int_request, .gap(4'h2), .int_accept);

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so it is sampled there.
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Settle the winner, then judge the codes loaded by the next acceptance.
    task automatic serve(input logic [11:0] el, input logic [11:0] es);
        int n;
        repeat (4) @(posedge ref_clk);
        for (n = 0; n < 20 && int_accept !== 1'b1; n++) @(posedge ref_clk);
        @(posedge ref_clk);
        #1 chk({4'h0, lc}, {4'h0, el});
        chk({4'h0, sc}, {4'h0, es});
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 5; i++) rd(4'(i), 16'h0000);
        rd(4'h5, 16'h8000);
        rd(4'h6, 16'h4000);
    endtask
    // All grouped sources stand at level zero, so none may be presented.
    task automatic t_mask;
        @(posedge ref_clk) rest <= '1;
        repeat (4) @(posedge ref_clk);
        #1 chk({15'h0, int_request}, 16'h0000);
        rest <= '0;
        for (int i = 0; i < 5; i++) begin
            wr(4'(i), PRIO_MASK[i]);
            rd(4'(i), PRIO_MASK[i]);
            wr(4'(i), 16'h0000);
        end
        rd(4'hF, 16'h0000);
    endtask
    task automatic t_dma;
        wr(4'h4, 16'h5000);
        @(posedge ref_clk) dma <= 4'b0110;
        serve(12'h340, 12'h820);
        chk({11'h0, int_level}, 16'h0005);
        @(posedge ref_clk) mask <= 4'h5;
        #1 chk({15'h0, int_request}, 16'h0000);
        mask <= 4'h4;
        #1 chk({15'h0, int_request}, 16'h0001);
        @(posedge ref_clk) dma <= 4'h0;
        mask <= 4'h0;
        wr(4'h4, 16'h0000);
    endtask
    task automatic t_tie;
        wr(4'h0, 16'h00F0);
        @(posedge ref_clk) {dbg, rest[14:13]} <= 3'b111;
        serve(12'h5E0, 12'h5E0);
        @(posedge ref_clk) dbg <= 1'b0;
        serve(12'h440, 12'h440);
        @(posedge ref_clk) rest[13] <= 1'b0;
        serve(12'h460, 12'h460);
        @(posedge ref_clk) rest[14] <= 1'b0;
        wr(4'h0, 16'h0000);
    endtask
    task automatic t_enc;
        @(posedge ref_clk) bus <= 4'h0;
        serve(12'h200, 12'h200);
        chk({11'h0, int_level}, 16'h000F);
        @(posedge ref_clk) bus <= 4'hE;
        serve(12'h3C0, 12'h3C0);
        @(posedge ref_clk) bus <= 4'hF;
        repeat (4) @(posedge ref_clk);
        #1 chk({15'h0, int_request}, 16'h0000);
    endtask
    task automatic t_nmi;
        @(posedge ref_clk) nmi_pin <= 1'b0;
        serve(12'h1C0, 12'h1C0);
        rd(4'h5, 16'h0000);
        wr(4'h5, 16'h0100);
        rd(4'h5, 16'h0100);
        // Wait out the blind window before the rising edge.
        repeat (20) @(posedge ref_clk);
        nmi_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk({11'h0, int_level}, 16'h0010);
    endtask
    // Separate pin mode, then hardware standby masks the pin again.
    task automatic t_pins;
        wr(4'h6, 16'h0000);
        wr(4'h2, 16'h0003);
        @(posedge ref_clk) rest[0] <= 1'b1;
        serve(12'h380, 12'h600);
        @(posedge ref_clk) hw_stby <= 1'b1;
        @(posedge ref_clk) hw_stby <= 1'b0;
        rd(4'h2, 16'h0000);
        rd(4'h6, 16'h0000);
        chk({15'h0, int_request}, 16'h0000);
        @(posedge ref_clk) rest[0] <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Clock, main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, dbg, dma, rest, hw_stby, mask} = '0;
        nmi_pin = 1'b1;
        bus = 4'hF;
        mismatches = 0;
        comparisons = 0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_mask();
        t_dma();
        t_tie();
        t_enc();
        t_pins();
        t_nmi();
        end_of_test();
    end
    initial begin
        #(25 * 5000);
        mismatches++;
        end_of_test();
    end
endmodule
